// ---- design/fault_and_channel_config_regs.sv ----
// Fault threshold control, per-channel settings and fault status registers
`include "fault_cfg_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fault_and_channel_config_regs
  import fault_cfg_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int LEVEL_W  = 10
) (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire reg_req_type              reg_req,
  output logic [7:0]                    reg_rdata,
  input  wire logic [LEVEL_W-1:0]       pos_pin_level [CHANNELS],
  input  wire logic [LEVEL_W-1:0]       neg_pin_level [CHANNELS],
  output per_channel_settings_type      chan_settings [CHANNELS],
  output logic [LEVEL_W-1:0]            thr_high,
  output logic [LEVEL_W-1:0]            thr_low,
  output logic [CHANNELS-1:0]           positive_pin_over_threshold,
  output logic [CHANNELS-1:0]           negative_pin_over_threshold
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]               comparator_threshold_code_q;
  per_channel_settings_type chan_q [CHANNELS];
  logic [LEVEL_W-1:0]       thr_high_q;
  logic [LEVEL_W-1:0]       thr_low_q;
  logic [LEVEL_W-1:0]       thr_high_d;
  logic [CHANNELS-1:0]      positive_fault_flags_q;
  logic [CHANNELS-1:0]      negative_fault_flags_q;
  logic [LEVEL_W-1:0]       pos_s1_q [CHANNELS];
  logic [LEVEL_W-1:0]       pos_s2_q [CHANNELS];
  logic [LEVEL_W-1:0]       neg_s1_q [CHANNELS];
  logic [LEVEL_W-1:0]       neg_s2_q [CHANNELS];
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic [7:0]               chan_idx;
  logic                     chan_hit;

  assign chan_idx = reg_req.addr - `ADDR_CHAN_FIRST;
  assign chan_hit = (reg_req.addr >= `ADDR_CHAN_FIRST) && (reg_req.addr <= `ADDR_CHAN_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold code storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator_threshold_code_q <= `RST_FAULT_CTRL;
    end else if (reg_req.wr_en && reg_req.addr == `ADDR_FAULT_CTRL) begin
      comparator_threshold_code_q <= reg_req.wdata[`CODE_MSB:`CODE_LSB];
    end
  end

  always_comb begin
    unique case (comparator_threshold_code_q)
      3'h0: thr_high_d = `THR_HI_0;
      3'h1: thr_high_d = `THR_HI_1;
      3'h2: thr_high_d = `THR_HI_2;
      3'h3: thr_high_d = `THR_HI_3;
      3'h4: thr_high_d = `THR_HI_4;
      3'h5: thr_high_d = `THR_HI_5;
      3'h6: thr_high_d = `THR_HI_6;
      3'h7: thr_high_d = `THR_HI_7;
    endcase
  end

  // Registered so the comparator DACs never see a decode glitch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_high_q <= `THR_HI_0;
      thr_low_q  <= `FULL_SCALE - `THR_HI_0;
    end else begin
      thr_high_q <= thr_high_d;
      thr_low_q  <= `FULL_SCALE - thr_high_d;
    end
  end

  assign thr_high = thr_high_q;
  assign thr_low  = thr_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel settings, synchronisers and comparators
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          chan_q[g] <= per_channel_settings_type'({`RST_CHAN} >> 1);
        end else if (reg_req.wr_en && chan_hit && chan_idx == 8'(g)) begin
          // Codes kept as written; host avoids illegal ones
          chan_q[g] <= {reg_req.wdata[`PD_BIT],
                        reg_req.wdata[`GAIN_MSB:`GAIN_LSB],
                        reg_req.wdata[`MUX_MSB:`MUX_LSB]};
        end
      end
      assign chan_settings[g] = chan_q[g];

      // Levels are quasi-static; two flops only guard metastability
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          pos_s1_q[g] <= '0;
          pos_s2_q[g] <= '0;
          neg_s1_q[g] <= '0;
          neg_s2_q[g] <= '0;
        end else begin
          pos_s1_q[g] <= pos_pin_level[g];
          pos_s2_q[g] <= pos_s1_q[g];
          neg_s1_q[g] <= neg_pin_level[g];
          neg_s2_q[g] <= neg_s1_q[g];
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          positive_fault_flags_q[g] <= 1'b0;
          negative_fault_flags_q[g] <= 1'b0;
        end else begin
          positive_fault_flags_q[g] <= (pos_s2_q[g] > thr_high_q) || (pos_s2_q[g] < thr_low_q);
          negative_fault_flags_q[g] <= (neg_s2_q[g] > thr_high_q) || (neg_s2_q[g] < thr_low_q);
        end
      end

      // Skip the release edge: flags were held in reset there
      a_flag_compare: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) |-> positive_fault_flags_q[g] ==
        $past((pos_s2_q[g] > thr_high_q) || (pos_s2_q[g] < thr_low_q)))
        else $error("positive flag disagrees with comparison");

      a_neg_compare: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) |-> negative_fault_flags_q[g] ==
        $past((neg_s2_q[g] > thr_high_q) || (neg_s2_q[g] < thr_low_q)))
        else $error("negative flag disagrees with comparison");

      a_pos_sync: assert property (@(posedge clk) disable iff (!arst_n)
        pos_s2_q[g] == $past(pos_s1_q[g]))
        else $error("positive level synchroniser broken");

      a_neg_sync: assert property (@(posedge clk) disable iff (!arst_n)
        neg_s2_q[g] == $past(neg_s1_q[g]))
        else $error("negative level synchroniser broken");

      a_chan_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !(reg_req.wr_en && chan_hit && chan_idx == 8'(g)) |=> $stable(chan_q[g]))
        else $error("channel settings changed without write");

      a_chan_store: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_req.wr_en && chan_hit && chan_idx == 8'(g)) |=>
        chan_q[g] == $past({reg_req.wdata[`PD_BIT], reg_req.wdata[`GAIN_MSB:`GAIN_LSB],
                            reg_req.wdata[`MUX_MSB:`MUX_LSB]}))
        else $error("channel settings not stored");
    end
  endgenerate

  assign positive_pin_over_threshold = positive_fault_flags_q;
  assign negative_pin_over_threshold = negative_fault_flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency
  always_comb begin
    rdata_d = `READ_ZERO;
    if (reg_req.addr == `ADDR_FAULT_CTRL) begin
      rdata_d = {comparator_threshold_code_q, 5'h00};
    end else if (chan_hit) begin
      rdata_d = {chan_q[chan_idx[2:0]].channel_power_down,
                 chan_q[chan_idx[2:0]].amplifier_gain_code, 1'b0,
                 chan_q[chan_idx[2:0]].channel_input_select};
    end else if (reg_req.addr == `ADDR_STAT_POS) begin
      rdata_d = 8'(positive_fault_flags_q);
    end else if (reg_req.addr == `ADDR_STAT_NEG) begin
      rdata_d = 8'(negative_fault_flags_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `RST_STAT;
    end else if (reg_req.rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  a_code_write: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.wr_en && reg_req.addr == `ADDR_FAULT_CTRL) |=>
    comparator_threshold_code_q == $past(reg_req.wdata[`CODE_MSB:`CODE_LSB]))
    else $error("threshold code not stored");

  a_high_decode: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h1) [*2] |-> thr_high_q == `THR_HI_1)
    else $error("high threshold for code 1 wrong");

  a_low_decode: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h7) [*2] |-> thr_low_q == `THR_LO_7)
    else $error("low threshold for code 7 wrong");

  a_pair_sum: assert property (@(posedge clk) disable iff (!arst_n)
    thr_high_q + thr_low_q == `FULL_SCALE && thr_high_q <= `THR_HI_0)
    else $error("threshold pair not complementary");

  a_fault_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && reg_req.addr == `ADDR_FAULT_CTRL) |=> reg_rdata[4:0] == 5'h00)
    else $error("fault control reserved bits not zero");

  a_chan_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && chan_hit) |=> reg_rdata[3] == 1'b0)
    else $error("channel reserved bit not zero");

  a_chan_write: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.wr_en && reg_req.addr == `ADDR_CHAN_LAST) |=>
    chan_settings[CHANNELS-1].channel_power_down == $past(reg_req.wdata[`PD_BIT]) &&
    chan_settings[CHANNELS-1].amplifier_gain_code == $past(reg_req.wdata[`GAIN_MSB:`GAIN_LSB]))
    else $error("channel 8 settings not stored");

  a_stat_read: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && reg_req.addr == `ADDR_STAT_POS) |=>
    reg_rdata == 8'($past(positive_fault_flags_q)))
    else $error("positive status read wrong");

  a_neg_read: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && reg_req.addr == `ADDR_STAT_NEG) |=>
    reg_rdata == 8'($past(negative_fault_flags_q)))
    else $error("negative status read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Rest of the decode table: high codes 0 and 2-7, low codes 0-6, one check each
  a_high_code0: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h0) [*2] |-> thr_high_q == `THR_HI_0)
    else $error("high threshold for code 0 wrong");

  a_high_code2: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h2) [*2] |-> thr_high_q == `THR_HI_2)
    else $error("high threshold for code 2 wrong");

  a_high_code3: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h3) [*2] |-> thr_high_q == `THR_HI_3)
    else $error("high threshold for code 3 wrong");

  a_high_code4: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h4) [*2] |-> thr_high_q == `THR_HI_4)
    else $error("high threshold for code 4 wrong");

  a_high_code5: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h5) [*2] |-> thr_high_q == `THR_HI_5)
    else $error("high threshold for code 5 wrong");

  a_high_code6: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h6) [*2] |-> thr_high_q == `THR_HI_6)
    else $error("high threshold for code 6 wrong");

  a_high_code7: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h7) [*2] |-> thr_high_q == `THR_HI_7)
    else $error("high threshold for code 7 wrong");

  a_low_code0: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h0) [*2] |-> thr_low_q == `THR_LO_0)
    else $error("low threshold for code 0 wrong");

  a_low_code1: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h1) [*2] |-> thr_low_q == `THR_LO_1)
    else $error("low threshold for code 1 wrong");

  a_low_code2: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h2) [*2] |-> thr_low_q == `THR_LO_2)
    else $error("low threshold for code 2 wrong");

  a_low_code3: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h3) [*2] |-> thr_low_q == `THR_LO_3)
    else $error("low threshold for code 3 wrong");

  a_low_code4: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h4) [*2] |-> thr_low_q == `THR_LO_4)
    else $error("low threshold for code 4 wrong");

  a_low_code5: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h5) [*2] |-> thr_low_q == `THR_LO_5)
    else $error("low threshold for code 5 wrong");

  a_low_code6: assert property (@(posedge clk) disable iff (!arst_n)
    (comparator_threshold_code_q == 3'h6) [*2] |-> thr_low_q == `THR_LO_6)
    else $error("low threshold for code 6 wrong");

  a_high_floor: assert property (@(posedge clk) disable iff (!arst_n)
    thr_high_q >= `THR_HI_7)
    else $error("high threshold below table");

  a_low_ceiling: assert property (@(posedge clk) disable iff (!arst_n)
    thr_low_q <= `THR_LO_7)
    else $error("low threshold above table");

  a_thr_order: assert property (@(posedge clk) disable iff (!arst_n)
    thr_low_q < thr_high_q)
    else $error("low threshold not below high");

  a_high_registered: assert property (@(posedge clk) disable iff (!arst_n)
    thr_high_q == $past(thr_high_d))
    else $error("high threshold not registered decode");

  a_low_registered: assert property (@(posedge clk) disable iff (!arst_n)
    thr_low_q + $past(thr_high_d) == `FULL_SCALE)
    else $error("low threshold not registered mirror");

  ////////////////////////////////////////////////////////////////////////////
  // Register port behaviour
  a_code_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !(reg_req.wr_en && reg_req.addr == `ADDR_FAULT_CTRL) |=> $stable(comparator_threshold_code_q))
    else $error("threshold code changed without write");

  a_code_read: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && reg_req.addr == `ADDR_FAULT_CTRL) |=> reg_rdata[7:5] == $past(comparator_threshold_code_q))
    else $error("threshold code read wrong");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_req.rd_en |=> $stable(reg_rdata))
    else $error("read data moved without read");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && !chan_hit && reg_req.addr != `ADDR_FAULT_CTRL &&
     reg_req.addr != `ADDR_STAT_POS && reg_req.addr != `ADDR_STAT_NEG) |=> reg_rdata == `READ_ZERO)
    else $error("unmapped read not zero");

  a_chan_read: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.rd_en && reg_req.addr == `ADDR_CHAN_FIRST) |=>
    reg_rdata == {$past(chan_q[0].channel_power_down), $past(chan_q[0].amplifier_gain_code),
                  1'b0, $past(chan_q[0].channel_input_select)})
    else $error("channel 1 read wrong");

  a_first_write: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.wr_en && reg_req.addr == `ADDR_CHAN_FIRST) |=>
    chan_settings[0].channel_power_down == $past(reg_req.wdata[`PD_BIT]) &&
    chan_settings[0].amplifier_gain_code == $past(reg_req.wdata[`GAIN_MSB:`GAIN_LSB]))
    else $error("channel 1 settings not stored");

  a_mux_write: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_req.wr_en && reg_req.addr == `ADDR_CHAN_LAST) |=>
    chan_settings[CHANNELS-1].channel_input_select == $past(reg_req.wdata[`MUX_MSB:`MUX_LSB]))
    else $error("channel 8 input select not stored");

endmodule

`default_nettype wire

// ---- design/fault_cfg_consts.svh ----
// Register map, field layout, reset values and threshold table
// Functional notes
// - Fault control at 04h, reset 0, code bits 7-5
// - High threshold decoded from comparator threshold code
// - Low threshold decoded from same code
// - Reserved bits read zero; host writes zero
// - Eight channel registers 05h-0Ch, reset 10h
// - Bit 7 powers channel down
// - Bits 6-4 amplifier gain; illegal codes avoided
// - Bits 2-0 input select; illegal codes avoided
// - Positive fault flags at 12h, channel order
// - Negative fault flags at 13h, same order
// - Flags compare pins against selected threshold pair
// - Status registers read-only, zero after reset
`ifndef FAULT_CFG_CONSTS_SVH
`define FAULT_CFG_CONSTS_SVH

`define ADDR_FAULT_CTRL   8'h04
`define ADDR_CHAN_FIRST   8'h05
`define ADDR_CHAN_LAST    8'h0C
`define ADDR_STAT_POS     8'h12
`define ADDR_STAT_NEG     8'h13

`define RST_FAULT_CTRL    3'h0
`define RST_CHAN          8'h10
`define RST_STAT          8'h00
`define READ_ZERO         8'h00

`define CODE_MSB          7
`define CODE_LSB          5
`define PD_BIT            7
`define GAIN_MSB          6
`define GAIN_LSB          4
`define MUX_MSB           2
`define MUX_LSB           0

// Thresholds in tenths of a percent of full scale
`define FULL_SCALE        10'h3E8
`define THR_HI_0          10'h3B6
`define THR_HI_1          10'h39D
`define THR_HI_2          10'h384
`define THR_HI_3          10'h36B
`define THR_HI_4          10'h352
`define THR_HI_5          10'h320
`define THR_HI_6          10'h2EE
`define THR_HI_7          10'h2BC
`define THR_LO_0          10'h032
`define THR_LO_1          10'h04B
`define THR_LO_2          10'h064
`define THR_LO_3          10'h07D
`define THR_LO_4          10'h096
`define THR_LO_5          10'h0C8
`define THR_LO_6          10'h0FA
`define THR_LO_7          10'h12C

`endif

// ---- design/fault_cfg_pkg.sv ----
// Types shared by the fault and channel configuration registers
package fault_cfg_pkg;

  typedef struct packed {
    logic       channel_power_down;
    logic [2:0] amplifier_gain_code;
    logic [2:0] channel_input_select;
  } per_channel_settings_type;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage

// ---- verification/reg_host_model.sv ----
// Register host model driving the block's request port
`timescale 1ns/10ps
`default_nettype none

module reg_host_model
  import fault_cfg_pkg::*;
(
  input  wire logic       clk,
  output var reg_req_type reg_req,
  input  wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '0;
  endtask

  // Data sampled once the answer edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// ---- verification/fault_and_channel_config_regs_bench.sv ----
// Self-checking bench for the fault and channel configuration registers
`timescale 1ns/10ps
`default_nettype none

module fault_and_channel_config_regs_bench
  import fault_cfg_pkg::*;
;
  logic                     clk = 1'b0;
  logic                     arst_n = 1'b0;
  reg_req_type              reg_req;
  logic [7:0]               reg_rdata;
  logic [7:0]               rd_val;
  logic [7:0]               exp_v;
  logic [9:0]               pos_lvl [8];
  logic [9:0]               neg_lvl [8];
  per_channel_settings_type chan_set [8];
  logic [9:0]               thr_high;
  logic [9:0]               thr_low;
  logic [7:0]               pos_flag;
  logic [7:0]               neg_flag;
  int                       error_cnt = 0;
  int                       tests_run = 0;
  logic [9:0] hi_tab [8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
  logic [2:0] gain_tab [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [2:0] mux_tab [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};

  always #10 clk = ~clk;

  fault_and_channel_config_regs u_fault_and_channel_config_regs (
    .clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pos_pin_level(pos_lvl), .neg_pin_level(neg_lvl), .chan_settings(chan_set),
    .thr_high(thr_high), .thr_low(thr_low),
    .positive_pin_over_threshold(pos_flag), .negative_pin_over_threshold(neg_flag));

  reg_host_model u_reg_host_model (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] exp);
    u_reg_host_model.rd(a, rd_val);
    check(n, {2'b00, rd_val}, {2'b00, exp});
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expired");
    complete_run();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      pos_lvl[i] = 10'h1F4;
      neg_lvl[i] = 10'h1F4;
    end
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rchk("fault_ctrl_rst", 8'h04, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rchk("chan_rst", 8'h05 + 8'(k), 8'h10);
    end
    rchk("stat_pos_rst", 8'h12, 8'h00);
    rchk("stat_neg_rst", 8'h13, 8'h00);
    u_reg_host_model.wr(8'h04, 8'hFF);
    rchk("fault_ctrl_rsvd", 8'h04, 8'hE0);
    for (int c = 0; c < 8; c++) begin
      u_reg_host_model.wr(8'h04, {3'(c), 5'h00});
      repeat (3) @(posedge clk);
      #1;
      check("thr_high", thr_high, hi_tab[c]);
      check("thr_low", thr_low, 10'h3E8 - hi_tab[c]);
    end
    // Reserved bit 3 set on purpose to see it dropped
    for (int k = 0; k < 8; k++) begin
      exp_v = {k[0], gain_tab[k % 5], 1'b0, mux_tab[k % 5]};
      u_reg_host_model.wr(8'h05 + 8'(k), exp_v | 8'h08);
      rchk("chan_rdback", 8'h05 + 8'(k), exp_v);
      check("chan_fields", {3'h0, chan_set[k]}, {3'h0, exp_v[7:4], exp_v[2:0]});
    end
    u_reg_host_model.wr(8'h04, 8'h00);
    @(posedge clk);
    pos_lvl[2] <= 10'h3E7;
    neg_lvl[5] <= 10'h00A;
    pos_lvl[0] <= 10'h384;
    repeat (5) @(posedge clk);
    rchk("stat_pos", 8'h12, 8'h04);
    rchk("stat_neg", 8'h13, 8'h20);
    u_reg_host_model.wr(8'h04, 8'h80);
    repeat (4) @(posedge clk);
    rchk("stat_pos_code4", 8'h12, 8'h05);
    u_reg_host_model.wr(8'h12, 8'h00);
    rchk("stat_read_only", 8'h12, 8'h05);
    rchk("unmapped", 8'h20, 8'h00);
    @(posedge clk);
    pos_lvl[0] <= 10'h1F4;
    pos_lvl[2] <= 10'h1F4;
    neg_lvl[5] <= 10'h1F4;
    repeat (5) @(posedge clk);
    #1;
    check("flags_live", {2'b00, pos_flag | neg_flag}, 10'h000);
    complete_run();
  end
endmodule

`default_nettype wire
